// File: inc/dsa_pkg.sv
// Function
// - pointer post-increment: byte by one, word by two
// - byte read picks lane by address bit zero
// - two byte lanes, shared word decode, own enables
// - byte write enables only the addressed lane
// - odd-address word access raises address error trap
// - misaligned read completes, then trap is taken
// - misaligned write suppressed, instruction finishes, then trap
// - byte load into working register keeps upper byte
// - sign extension of low byte to sixteen bits
// - zero extension clears upper byte of register
// - 0x0000 to 0x07ff decodes special function registers, except w4, which decodes at 0x8000
// - unused special register addresses read as zero
// - near space reached by 13-bit direct field
// - whole space via 16-bit direct or pointer
// - unimplemented register bits read as zero
// - access outside implemented memory returns zero
// - low byte at even address, high at odd
package dsa_pkg;

    localparam logic [15:0] SFR_LAST      = 16'h07ff;
    localparam logic [15:0] NEAR_LAST     = 16'h1fff;
    localparam logic [15:0] RAM_BASE      = 16'h0800;
    localparam int          RAM_WORDS     = 512;
    localparam int          RAM_IDX_W     = 9;
    localparam logic [15:0] RAM_END       = 16'h0c00;

    localparam logic [15:0] W_OFS [16] = '{16'h0000, 16'h0002, 16'h0004, 16'h0006,
                                          16'h8000, 16'h000a, 16'h000c, 16'h000e,
                                          16'h0010, 16'h0012, 16'h0014, 16'h0016,
                                          16'h0018, 16'h001a, 16'h001c, 16'h001e};
    localparam logic [15:0] STACK_LIMIT_OFS  = 16'h0020;
    localparam logic [15:0] PC_LOW_OFS       = 16'h002e;
    localparam logic [15:0] PC_HIGH_OFS      = 16'h0030;
    localparam logic [15:0] TABLE_PAGE_OFS   = 16'h0032;
    localparam logic [15:0] VIS_PAGE_OFS     = 16'h0034;
    localparam logic [15:0] REPEAT_CNT_OFS   = 16'h0036;
    localparam logic [15:0] CORE_STATUS_OFS  = 16'h0042;
    localparam logic [15:0] CORE_CONTROL_OFS = 16'h0044;
    localparam logic [15:0] IRQ_DIS_CNT_OFS  = 16'h0052;

    localparam logic [15:0] SP_RESET         = 16'h0800;
    localparam logic [15:0] FULL_MASK        = 16'hffff;
    localparam logic [15:0] BYTE_MASK        = 16'h00ff;
    localparam logic [15:0] STATUS_MASK      = 16'h7fff;
    localparam logic [15:0] CONTROL_MASK     = 16'h000c;
    localparam logic [15:0] IRQ_DIS_MASK     = 16'h3fff;
    localparam logic [15:0] STEP_BYTE        = 16'h0001;
    localparam logic [15:0] STEP_WORD        = 16'h0002;

    typedef enum logic [3:0] {
        OP_READ      = 4'b0001,
        OP_WRITE     = 4'b0010,
        OP_SIGN_EXT  = 4'b0100,
        OP_ZERO_EXT  = 4'b1000
    } op_type;

    typedef enum logic [3:0] {
        MODE_NEAR13   = 4'b0001,
        MODE_DIRECT16 = 4'b0010,
        MODE_INDIRECT = 4'b0100,
        MODE_POST_INC = 4'b1000
    } mode_type;

    typedef struct packed {
        logic        valid;
        op_type      op;
        mode_type    mode;
        logic        byte_size;
        logic [15:0] direct_addr;
        logic [3:0]  ptr_reg;
        logic        load_en;
        logic [3:0]  load_reg;
        logic [15:0] wdata;
    } req_type;

    typedef struct packed {
        logic        valid;
        logic [15:0] rdata;
        logic [15:0] effective_address;
        logic        trap;
        logic        trap_on_write;
    } rsp_type;

    typedef struct packed {
        logic [15:0][15:0]          w;
        logic [15:0]                stack_limit;
        logic [15:0]                prog_counter_low;
        logic [15:0]                prog_counter_high;
        logic [15:0]                table_page_pointer;
        logic [15:0]                prog_visibility_page;
        logic [15:0]                repeat_loop_counter;
        logic [15:0]                core_status;
        logic [15:0]                core_control;
        logic [15:0]                irq_disable_counter;
        logic [RAM_WORDS-1:0][15:0] ram;
        rsp_type                    rsp;
    } state_type;

endpackage : dsa_pkg

// File: rtl/data_space_access_core_regs.sv
`timescale 1ns/1ps
`default_nettype none
module data_space_access_core_regs (
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire dsa_pkg::req_type req_i,
    output var  dsa_pkg::rsp_type rsp_o
);

    dsa_pkg::state_type s_q;
    dsa_pkg::state_type s_d;

    function automatic logic in_ram(input logic [15:0] a);
        in_ram = (a >= dsa_pkg::RAM_BASE) && (a < dsa_pkg::RAM_END);
    endfunction : in_ram

    function automatic logic [dsa_pkg::RAM_IDX_W-1:0] ram_idx(input logic [15:0] a);
        logic [15:0] off;
        off = a - dsa_pkg::RAM_BASE;
        ram_idx = off[dsa_pkg::RAM_IDX_W:1];
    endfunction : ram_idx

    // lanes: bit 0 low byte (even address), bit 1 high byte (odd address)
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] wd,
                                          input logic [1:0]  lanes,
                                          input logic [15:0] mask);
        logic [15:0] m;
        m = {{8{lanes[1]}}, {8{lanes[0]}}};
        merge = ((old & ~m) | (wd & m)) & mask;
    endfunction : merge

    // one word decoder shared by both lanes; unmatched words read zero
    function automatic logic [15:0] read_word(input dsa_pkg::state_type s,
                                              input logic [15:0] a);
        logic [15:0] wa;
        wa = {a[15:1], 1'b0};
        read_word = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            if (wa == dsa_pkg::W_OFS[i]) begin
                read_word = s.w[i];
            end
        end
        case (wa)
            dsa_pkg::STACK_LIMIT_OFS:  read_word = s.stack_limit;
            dsa_pkg::PC_LOW_OFS:       read_word = s.prog_counter_low;
            dsa_pkg::PC_HIGH_OFS:      read_word = s.prog_counter_high;
            dsa_pkg::TABLE_PAGE_OFS:   read_word = s.table_page_pointer;
            dsa_pkg::VIS_PAGE_OFS:     read_word = s.prog_visibility_page;
            dsa_pkg::REPEAT_CNT_OFS:   read_word = s.repeat_loop_counter;
            dsa_pkg::CORE_STATUS_OFS:  read_word = s.core_status;
            dsa_pkg::CORE_CONTROL_OFS: read_word = s.core_control;
            dsa_pkg::IRQ_DIS_CNT_OFS:  read_word = s.irq_disable_counter;
            default: begin
                if (in_ram(wa)) begin
                    read_word = s.ram[ram_idx(wa)];
                end
            end
        endcase
    endfunction : read_word

    function automatic dsa_pkg::state_type store(input dsa_pkg::state_type s,
                                                 input logic [15:0] a,
                                                 input logic [15:0] wd,
                                                 input logic [1:0]  lanes);
        logic [15:0] wa;
        wa = {a[15:1], 1'b0};
        store = s;
        for (int i = 0; i < 16; i++) begin
            if (wa == dsa_pkg::W_OFS[i]) begin
                store.w[i] = merge(s.w[i], wd, lanes, dsa_pkg::FULL_MASK);
            end
        end
        case (wa)
            dsa_pkg::STACK_LIMIT_OFS:
                store.stack_limit = merge(s.stack_limit, wd, lanes, dsa_pkg::FULL_MASK);
            dsa_pkg::PC_LOW_OFS:
                store.prog_counter_low = merge(s.prog_counter_low, wd, lanes,
                                               dsa_pkg::FULL_MASK);
            dsa_pkg::PC_HIGH_OFS:
                store.prog_counter_high = merge(s.prog_counter_high, wd, lanes,
                                                dsa_pkg::BYTE_MASK);
            dsa_pkg::TABLE_PAGE_OFS:
                store.table_page_pointer = merge(s.table_page_pointer, wd, lanes,
                                                 dsa_pkg::BYTE_MASK);
            dsa_pkg::VIS_PAGE_OFS:
                store.prog_visibility_page = merge(s.prog_visibility_page, wd, lanes,
                                                   dsa_pkg::BYTE_MASK);
            dsa_pkg::REPEAT_CNT_OFS:
                store.repeat_loop_counter = merge(s.repeat_loop_counter, wd, lanes,
                                                  dsa_pkg::FULL_MASK);
            dsa_pkg::CORE_STATUS_OFS:
                store.core_status = merge(s.core_status, wd, lanes, dsa_pkg::STATUS_MASK);
            dsa_pkg::CORE_CONTROL_OFS:
                store.core_control = merge(s.core_control, wd, lanes, dsa_pkg::CONTROL_MASK);
            dsa_pkg::IRQ_DIS_CNT_OFS:
                store.irq_disable_counter = merge(s.irq_disable_counter, wd, lanes,
                                                  dsa_pkg::IRQ_DIS_MASK);
            default: begin
                if (in_ram(wa)) begin
                    store.ram[ram_idx(wa)] = merge(s.ram[ram_idx(wa)], wd, lanes,
                                                   dsa_pkg::FULL_MASK);
                end
            end
        endcase
    endfunction : store

    logic [15:0] ea;
    logic        misaligned;
    logic [15:0] word_rd;
    logic [15:0] wdata_lanes;
    logic [1:0]  lanes;
    logic [7:0]  ext_byte;

    always_comb begin
        case (req_i.mode)
            dsa_pkg::MODE_NEAR13:   ea = {3'b000, req_i.direct_addr[12:0]};
            dsa_pkg::MODE_DIRECT16: ea = req_i.direct_addr;
            dsa_pkg::MODE_INDIRECT: ea = s_q.w[req_i.ptr_reg];
            dsa_pkg::MODE_POST_INC: ea = s_q.w[req_i.ptr_reg];
            default:                ea = req_i.direct_addr;
        endcase
        misaligned  = !req_i.byte_size && ea[0];
        word_rd     = read_word(s_q, ea);
        // byte data arrives on the low lane and is copied to both lanes
        wdata_lanes = req_i.byte_size ? {req_i.wdata[7:0], req_i.wdata[7:0]} : req_i.wdata;
        if (req_i.byte_size) begin
            lanes = ea[0] ? 2'b10 : 2'b01;
        end else begin
            lanes = 2'b11;
        end
        ext_byte = s_q.w[req_i.load_reg][7:0];
    end

    always_comb begin
        s_d = s_q;
        s_d.rsp = '0;
        if (req_i.valid) begin
            s_d.rsp.effective_address = ea;
            // increment lands before any store so a store to the pointer wins
            if (req_i.mode == dsa_pkg::MODE_POST_INC &&
                (req_i.op == dsa_pkg::OP_READ || req_i.op == dsa_pkg::OP_WRITE)) begin
                s_d.w[req_i.ptr_reg] = s_q.w[req_i.ptr_reg] +
                    (req_i.byte_size ? dsa_pkg::STEP_BYTE : dsa_pkg::STEP_WORD);
            end
            case (req_i.op)
                dsa_pkg::OP_READ: begin
                    s_d.rsp.valid = 1'b1;
                    // a misaligned read still completes with the even word
                    s_d.rsp.trap  = misaligned;
                    if (req_i.byte_size) begin
                        s_d.rsp.rdata = {8'h00, ea[0] ? word_rd[15:8] : word_rd[7:0]};
                    end else begin
                        s_d.rsp.rdata = word_rd;
                    end
                    if (req_i.load_en) begin
                        if (req_i.byte_size) begin
                            s_d.w[req_i.load_reg][7:0] = s_d.rsp.rdata[7:0];
                        end else begin
                            s_d.w[req_i.load_reg] = s_d.rsp.rdata;
                        end
                    end
                end
                dsa_pkg::OP_WRITE: begin
                    s_d.rsp.valid         = 1'b1;
                    s_d.rsp.trap          = misaligned;
                    s_d.rsp.trap_on_write = misaligned;
                    if (!misaligned) begin
                        s_d = store(s_d, ea, wdata_lanes, lanes);
                    end
                end
                dsa_pkg::OP_SIGN_EXT: begin
                    s_d.rsp.valid = 1'b1;
                    s_d.rsp.rdata = {{8{ext_byte[7]}}, ext_byte};
                    s_d.w[req_i.load_reg] = s_d.rsp.rdata;
                end
                dsa_pkg::OP_ZERO_EXT: begin
                    s_d.rsp.valid = 1'b1;
                    s_d.rsp.rdata = {8'h00, ext_byte};
                    s_d.w[req_i.load_reg] = s_d.rsp.rdata;
                end
                default: begin
                    s_d.rsp = '0;
                end
            endcase
        end
    end

    // unknown-reset registers are cleared too; software must not rely on it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q      <= '0;
            s_q.w[15] <= dsa_pkg::SP_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign rsp_o = s_q.rsp;

endmodule : data_space_access_core_regs
`default_nettype wire

// File: tb/data_space_access_core_regs_checker.sv
`timescale 1ns/1ps
`default_nettype none
module data_space_access_core_regs_checker (
    input wire logic             clk_i,
    input wire logic             rst_i,
    input wire dsa_pkg::req_type req_i,
    input wire dsa_pkg::rsp_type rsp_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic rd;
    logic rw;
    logic d16;
    assign rd  = req_i.valid && req_i.op == dsa_pkg::OP_READ;
    assign rw  = rd || (req_i.valid && req_i.op == dsa_pkg::OP_WRITE);
    assign d16 = req_i.mode == dsa_pkg::MODE_DIRECT16;
    sequence s_odd_word;
        rw && d16 && !req_i.byte_size && req_i.direct_addr[0];
    endsequence
    sequence s_trap_write;
        rsp_o.valid && rsp_o.trap && rsp_o.trap_on_write;
    endsequence
    AST_ODD_TRAP: assert property (s_odd_word |=> rsp_o.valid && rsp_o.trap)
        else $error("odd word access gave no trap");
    AST_WRITE_TRAP: assert property ((s_odd_word ##0 !rd) |=> s_trap_write)
        else $error("odd word write not flagged as write trap");
    AST_READ_TRAP: assert property ((s_odd_word ##0 rd) |=> !rsp_o.trap_on_write)
        else $error("odd word read flagged as write trap");
    AST_BYTE_NO_TRAP: assert property (rw && req_i.byte_size |=> !rsp_o.trap)
        else $error("byte access trapped");
    AST_BYTE_LANE: assert property (rd && req_i.byte_size |=> rsp_o.rdata[15:8] == 8'h00)
        else $error("byte read upper lane not zero");
    AST_EA_DIRECT: assert property (rw && d16 |=>
        rsp_o.effective_address == $past(req_i.direct_addr)) else $error("direct address wrong");
    AST_EA_NEAR: assert property (rw && req_i.mode == dsa_pkg::MODE_NEAR13 |=>
        rsp_o.effective_address == ($past(req_i.direct_addr) & 16'h1fff))
        else $error("near address wrong");
    AST_SIGN_EXT: assert property (req_i.valid && req_i.op == dsa_pkg::OP_SIGN_EXT |=>
        rsp_o.valid && rsp_o.rdata[15:8] == {8{rsp_o.rdata[7]}}) else $error("sign extend wrong");
    AST_ZERO_EXT: assert property (req_i.valid && req_i.op == dsa_pkg::OP_ZERO_EXT |=>
        rsp_o.valid && rsp_o.rdata[15:8] == 8'h00) else $error("zero extend wrong");
    AST_SFR_HOLE: assert property (rd && d16 && req_i.direct_addr inside {[16'h0054:16'h07ff]}
        |=> rsp_o.rdata == 16'h0000) else $error("unused register space not zero");
    AST_OUT_OF_RAM: assert property (rd && d16 && req_i.direct_addr inside {[16'h0c00:16'h7fff]}
        |=> rsp_o.rdata == 16'h0000) else $error("unimplemented memory not zero");
endmodule : data_space_access_core_regs_checker
`default_nettype wire

// File: tb/dsa_issue_model.sv
`timescale 1ns/1ps
`default_nettype none
module dsa_issue_model (
    input  wire logic             clk_i,
    output var  dsa_pkg::req_type req_o
);
    initial req_o = '0;
    // one request per falling edge, back to back; odd word addresses only when asked
    task automatic issue(input dsa_pkg::req_type r);
        @(negedge clk_i);
        req_o <= r;
    endtask : issue
    task automatic rest();
        @(negedge clk_i);
        req_o <= '0;
    endtask : rest
endmodule : dsa_issue_model
`default_nettype wire

// File: tb/data_space_access_core_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module data_space_access_core_regs_bench;
    typedef struct packed {logic chk; logic [15:0] rdata; logic trap;} note_type;
    logic             clk_i = 1'b0;
    logic             rst_i = 1'b1;
    dsa_pkg::req_type req_i;
    dsa_pkg::rsp_type rsp_o;
    note_type         notes[$];
    int               fails = 0;
    int               checks_done = 0;
    always #5 clk_i = ~clk_i;
    data_space_access_core_regs dut (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .rsp_o(rsp_o));
    dsa_issue_model partner (.clk_i(clk_i), .req_o(req_i));
    function automatic logic [15:0] next_rand(input logic [15:0] x);
        x = x ^ (x << 7);
        x = x ^ (x >> 9);
        return x ^ (x << 8);
    endfunction : next_rand
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        checks_done++;
        if (seen !== want) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, seen, want);
        end
    endtask : check
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    // pointer is always w1; load target nonzero means load
    task automatic go(input dsa_pkg::op_type o, input dsa_pkg::mode_type m, input logic bs,
                      input logic [15:0] a, input logic [15:0] wd, input logic [3:0] lr,
                      input logic chk, input logic [15:0] ed, input logic et);
        partner.issue('{1'b1, o, m, bs, a, 4'h1, lr != 4'h0, lr, wd});
        notes.push_back('{chk, ed, et});
    endtask : go
    task automatic rdw(input logic [15:0] a, input logic [15:0] ed, input logic et);
        go(dsa_pkg::OP_READ, dsa_pkg::MODE_DIRECT16, 1'b0, a, 16'h0000, 4'h0, 1'b1, ed, et);
    endtask : rdw
    task automatic wrw(input logic [15:0] a, input logic [15:0] wd, input logic et);
        go(dsa_pkg::OP_WRITE, dsa_pkg::MODE_DIRECT16, 1'b0, a, wd, 4'h0, 1'b0, 16'h0000, et);
    endtask : wrw
    // result shows right after the taking edge, so compare on the next falling edge
    always @(negedge clk_i) begin
        note_type n;
        if (rsp_o.valid === 1'b1) begin
            if (notes.size() == 0) check(16'h0001, 16'h0000);
            else begin
                n = notes.pop_front();
                check({15'h0000, rsp_o.trap}, {15'h0000, n.trap});
                if (n.chk) check(rsp_o.rdata, n.rdata);
            end
        end
    end
    initial begin
        repeat (2000) @(posedge clk_i);
        fails++;
        give_verdict();
    end
    initial begin
        logic [15:0] r;
        r = next_rand(16'h8813);
        repeat (3) @(posedge clk_i);
        @(negedge clk_i) rst_i <= 1'b0;
        rdw(dsa_pkg::W_OFS[15], dsa_pkg::SP_RESET, 1'b0);
        rdw(16'h0008, 16'h0000, 1'b0);
        rdw(16'h0100, 16'h0000, 1'b0);
        $display("reset values done");
        wrw(16'h0800, r, 1'b0);
        go(dsa_pkg::OP_READ, dsa_pkg::MODE_DIRECT16, 1'b1, 16'h0800, 16'h0000, 4'h0, 1'b1,
           {8'h00, r[7:0]}, 1'b0);
        go(dsa_pkg::OP_READ, dsa_pkg::MODE_DIRECT16, 1'b1, 16'h0801, 16'h0000, 4'h0, 1'b1,
           {8'h00, r[15:8]}, 1'b0);
        go(dsa_pkg::OP_WRITE, dsa_pkg::MODE_DIRECT16, 1'b1, 16'h0801, 16'h00ab, 4'h0, 1'b0,
           16'h0000, 1'b0);
        rdw(16'h0800, {8'hab, r[7:0]}, 1'b0);
        $display("byte lanes done");
        wrw(16'h0802, 16'h5a5a, 1'b0);
        wrw(16'h0803, ~r, 1'b1);
        rdw(16'h0802, 16'h5a5a, 1'b0);
        rdw(16'h0801, {8'hab, r[7:0]}, 1'b1);
        $display("misaligned done");
        wrw(16'h0002, 16'h0800, 1'b0);
        go(dsa_pkg::OP_READ, dsa_pkg::MODE_POST_INC, 1'b1, 16'h0000, 16'h0000, 4'h0, 1'b1,
           {8'h00, r[7:0]}, 1'b0);
        rdw(16'h0002, 16'h0801, 1'b0);
        go(dsa_pkg::OP_READ, dsa_pkg::MODE_POST_INC, 1'b0, 16'h0000, 16'h0000, 4'h0, 1'b1,
           {8'hab, r[7:0]}, 1'b1);
        rdw(16'h0002, 16'h0803, 1'b0);
        go(dsa_pkg::OP_READ, dsa_pkg::MODE_INDIRECT, 1'b0, 16'h0000, 16'h0000, 4'h0, 1'b1,
           16'h5a5a, 1'b1);
        $display("pointer steps done");
        wrw(16'h0004, 16'h1234, 1'b0);
        go(dsa_pkg::OP_READ, dsa_pkg::MODE_DIRECT16, 1'b1, 16'h0801, 16'h0000, 4'h2, 1'b1,
           16'h00ab, 1'b0);
        rdw(16'h0004, 16'h12ab, 1'b0);
        go(dsa_pkg::OP_SIGN_EXT, dsa_pkg::MODE_DIRECT16, 1'b0, 16'h0000, 16'h0000, 4'h2, 1'b1,
           16'hffab, 1'b0);
        go(dsa_pkg::OP_ZERO_EXT, dsa_pkg::MODE_DIRECT16, 1'b0, 16'h0000, 16'h0000, 4'h2, 1'b1,
           16'h00ab, 1'b0);
        rdw(16'h0004, 16'h00ab, 1'b0);
        $display("loads and extends done");
        wrw(dsa_pkg::PC_HIGH_OFS, 16'hffff, 1'b0);
        rdw(dsa_pkg::PC_HIGH_OFS, 16'h00ff, 1'b0);
        rdw(16'h0c00, 16'h0000, 1'b0);
        go(dsa_pkg::OP_READ, dsa_pkg::MODE_NEAR13, 1'b0, 16'h0800, 16'h0000, 4'h0, 1'b1,
           {8'hab, r[7:0]}, 1'b0);
        partner.rest();
        repeat (3) @(negedge clk_i);
        check(16'(notes.size()), 16'h0000);
        $display("decode done");
        give_verdict();
    end
endmodule : data_space_access_core_regs_bench
bind data_space_access_core_regs data_space_access_core_regs_checker chk (
    .clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .rsp_o(rsp_o));
`default_nettype wire
